/* File: design/wpm_map.svh */
// Register offsets, field positions, reset values and timing for wpm_config
`ifndef WPM_MAP_SVH
`define WPM_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (8-bit register address)
// ----------------------------------------------------------------
`define WPM_ADDR_MEAS_MODE 8'h14
`define WPM_ADDR_WAVE_MODE 8'h15
`define WPM_ADDR_LINE_CYC 8'h1C
`define WPM_ADDR_V_THRESH 8'h1D
`define WPM_ADDR_I_THRESH 8'h1E
`define WPM_ADDR_IRQ_STAT 8'h1F
`define WPM_ADDR_IRQ_MASK 8'h20
`define WPM_ADDR_V_PEAK 8'h21
`define WPM_ADDR_I_PEAK 8'h22

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WPM_PEAK_SEL_LSB 2
`define WPM_PEAK_SEL_MSB 4
`define WPM_PKIRQ_SEL_LSB 5
`define WPM_PKIRQ_SEL_MSB 7
`define WPM_WAVEFORM_PHASE_SELECT_LSB 0
`define WPM_WAVEFORM_PHASE_SELECT_MSB 1
`define WPM_WAVEFORM_TYPE_SELECT_LSB 2
`define WPM_WAVEFORM_TYPE_SELECT_MSB 4
`define WPM_RATE_LSB 5
`define WPM_RATE_MSB 6
`define WPM_APPARENT_BIT 7
`define WPM_IRQ_V_BIT 0
`define WPM_IRQ_I_BIT 1
`define WPM_IRQ_WIN_BIT 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WPM_MEAS_MODE_RST 8'hFC
`define WPM_WAVE_MODE_RST 8'h00
`define WPM_IRQ_W 3

// ----------------------------------------------------------------
// Timing: update rate is master clock / 3 / (128 << rate code)
// ----------------------------------------------------------------
`define WPM_PRE_DIV 12'h003
`define WPM_RATE_BASE 12'h080
`define WPM_SAMP_W 24

`endif

/* File: design/wpm_pkg.sv */
// Types shared by the waveform and peak mode configuration block
package wpm_pkg;
  `include "wpm_map.svh"

  // One phase worth of datapath samples
  typedef struct packed {
    logic signed [`WPM_SAMP_W-1:0] volt;
    logic signed [`WPM_SAMP_W-1:0] curr;
    logic signed [`WPM_SAMP_W-1:0] act;
    logic signed [`WPM_SAMP_W-1:0] react;
    logic signed [`WPM_SAMP_W-1:0] app;
  } wpm_phase_t;

  // Waveform type codes
  typedef enum logic [2:0] {
    WPM_WAV_CURR = 3'h0,
    WPM_WAV_VOLT = 3'h1,
    WPM_WAV_ACT = 3'h2,
    WPM_WAV_REACT = 3'h3,
    WPM_WAV_APP = 3'h4
  } wpm_waveform_type_select_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } wpm_req_t;
endpackage : wpm_pkg

/* File: design/wpm_config.sv */
// Waveform and peak mode configuration with peak capture and interrupts
`timescale 1ns/1ns
`default_nettype none
`include "wpm_map.svh"

// Contract
// - Peak select bits 2-4 reset 7; bit2 phase A
// - Bit3 enables phase B, bit4 phase C
// - Holds reload at end of half-cycle window
// - Voltage and current peaks tracked independently
// - Peak irq select bits 5-7 reset 7
// - Any combination of irq phases allowed
// - Waveform phase bits 0-1: A, B, C
// - Waveform type bits 2-4 pick source
// - Rate bits 5-6 divide clock 3x(128..1024)
// - Bit7 routes apparent or reactive pulse
module wpm_config import wpm_pkg::*; #(
  parameter int LCYC_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire wpm_req_t req,
  output logic [15:0] rdata,
  // Sample datapath
  input wire wpm_phase_t [2:0] phase_in,
  input wire logic sample_valid,
  input wire logic half_cycle,
  // Pulse sources and pulse output
  input wire logic reactive_freq_in,
  input wire logic apparent_freq_in,
  output logic reactive_pulse_output,
  // Waveform sampling output
  output logic wave_strobe,
  output logic signed [`WPM_SAMP_W-1:0] wave_data,
  // Interrupt
  output logic irq
);
  localparam int SW = `WPM_SAMP_W;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Magnitude as unsigned; the most negative code still fits in SW bits
  function automatic logic [SW-1:0] mag(input logic signed [SW-1:0] x);
    mag = x[SW-1] ? (SW)'(-x) : x;
  endfunction : mag

  // Address match, used by write decode and the status clear; read decode uses a case
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] meas_mode_reg, meas_mode_next;
  logic [7:0] wave_mode_reg, wave_mode_next;
  logic [LCYC_W-1:0] line_cyc_reg, line_cyc_next;
  logic [SW-1:0] v_thr_reg, v_thr_next;
  logic [SW-1:0] i_thr_reg, i_thr_next;
  logic [`WPM_IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [`WPM_IRQ_W-1:0] irq_stat_reg;
  logic [SW-1:0] v_hold_reg, i_hold_reg;

  wire logic [2:0] peak_sel = meas_mode_reg[`WPM_PEAK_SEL_MSB:`WPM_PEAK_SEL_LSB];
  wire logic [2:0] pkirq_sel =
    meas_mode_reg[`WPM_PKIRQ_SEL_MSB:`WPM_PKIRQ_SEL_LSB];
  wire logic [1:0] ph_sel = wave_mode_reg[`WPM_WAVEFORM_PHASE_SELECT_MSB:`WPM_WAVEFORM_PHASE_SELECT_LSB];
  wire logic [2:0] wav_sel = wave_mode_reg[`WPM_WAVEFORM_TYPE_SELECT_MSB:`WPM_WAVEFORM_TYPE_SELECT_LSB];
  wire logic [1:0] rate_sel = wave_mode_reg[`WPM_RATE_MSB:`WPM_RATE_LSB];
  wire logic apparent_sel = wave_mode_reg[`WPM_APPARENT_BIT];

  // Writes store; reads return data only in the following cycle
  always_comb begin
    meas_mode_next = meas_mode_reg;
    wave_mode_next = wave_mode_reg;
    line_cyc_next = line_cyc_reg;
    v_thr_next = v_thr_reg;
    i_thr_next = i_thr_reg;
    irq_mask_next = irq_mask_reg;
    rdata_next = 16'h0000;
    if (req.wr) begin
      if (hit(req.addr, `WPM_ADDR_MEAS_MODE)) begin
        meas_mode_next = req.wdata[7:0];
      end
      if (hit(req.addr, `WPM_ADDR_WAVE_MODE)) begin
        wave_mode_next = req.wdata[7:0];
      end
      if (hit(req.addr, `WPM_ADDR_LINE_CYC)) begin
        line_cyc_next = req.wdata[LCYC_W-1:0];
      end
      if (hit(req.addr, `WPM_ADDR_V_THRESH)) begin
        v_thr_next = {req.wdata, 8'h00}; // Upper bits of sample scale
      end
      if (hit(req.addr, `WPM_ADDR_I_THRESH)) begin
        i_thr_next = {req.wdata, 8'h00};
      end
      if (hit(req.addr, `WPM_ADDR_IRQ_MASK)) begin
        irq_mask_next = req.wdata[`WPM_IRQ_W-1:0];
      end
    end
    if (req.rd) begin
      case (req.addr)
        `WPM_ADDR_MEAS_MODE: rdata_next = {8'h00, meas_mode_reg};
        `WPM_ADDR_WAVE_MODE: rdata_next = {8'h00, wave_mode_reg};
        `WPM_ADDR_LINE_CYC: rdata_next = 16'(line_cyc_reg);
        `WPM_ADDR_V_THRESH: rdata_next = v_thr_reg[SW-1:8];
        `WPM_ADDR_I_THRESH: rdata_next = i_thr_reg[SW-1:8];
        `WPM_ADDR_IRQ_STAT: rdata_next = 16'(irq_stat_reg);
        `WPM_ADDR_IRQ_MASK: rdata_next = 16'(irq_mask_reg);
        `WPM_ADDR_V_PEAK: rdata_next = v_hold_reg[SW-1:8];
        `WPM_ADDR_I_PEAK: rdata_next = i_hold_reg[SW-1:8];
        default: rdata_next = 16'h0000; // Unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meas_mode_reg <= `WPM_MEAS_MODE_RST;
      wave_mode_reg <= `WPM_WAVE_MODE_RST;
      line_cyc_reg <= '0;
      v_thr_reg <= '1;
      i_thr_reg <= '1;
      irq_mask_reg <= '0;
      rdata_reg <= 16'h0000;
    end else begin
      meas_mode_reg <= meas_mode_next;
      wave_mode_reg <= wave_mode_next;
      line_cyc_reg <= line_cyc_next;
      v_thr_reg <= v_thr_next;
      i_thr_reg <= i_thr_next;
      irq_mask_reg <= irq_mask_next;
      rdata_reg <= rdata_next;
    end
  end
  assign rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Peak detection over a half-cycle window
  // ----------------------------------------------------------------
  logic [SW-1:0] v_run_reg, v_run_next, i_run_reg, i_run_next;
  logic [SW-1:0] v_hold_next, i_hold_next;
  logic [LCYC_W-1:0] hc_cnt_reg, hc_cnt_next;
  logic win_end;
  logic [LCYC_W-1:0] lc_last;

  // A zero count would never close the window, so treat it as one
  always_comb begin
    lc_last = (line_cyc_reg == '0) ? '0 : line_cyc_reg - 1'b1;
    win_end = half_cycle && (hc_cnt_reg >= lc_last);
    v_run_next = v_run_reg;
    i_run_next = i_run_reg;
    v_hold_next = v_hold_reg;
    i_hold_next = i_hold_reg;
    hc_cnt_next = hc_cnt_reg;
    if (half_cycle) begin
      hc_cnt_next = win_end ? '0 : hc_cnt_reg + 1'b1;
    end
    // Voltage and current maxima kept apart, may come from two phases
    if (sample_valid) begin
      for (int p = 0; p < 3; p++) begin
        if (peak_sel[p] && mag(phase_in[p].volt) > v_run_next) begin
          v_run_next = mag(phase_in[p].volt);
        end
        if (peak_sel[p] && mag(phase_in[p].curr) > i_run_next) begin
          i_run_next = mag(phase_in[p].curr);
        end
      end
    end
    // A sample landing on the closing edge is dropped from both windows
    if (win_end) begin
      v_hold_next = v_run_reg;
      i_hold_next = i_run_reg;
      v_run_next = '0;
      i_run_next = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      v_run_reg <= '0;
      i_run_reg <= '0;
      v_hold_reg <= '0;
      i_hold_reg <= '0;
      hc_cnt_reg <= '0;
    end else begin
      v_run_reg <= v_run_next;
      i_run_reg <= i_run_next;
      v_hold_reg <= v_hold_next;
      i_hold_reg <= i_hold_next;
      hc_cnt_reg <= hc_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Peak-level interrupts
  // ----------------------------------------------------------------
  logic [`WPM_IRQ_W-1:0] irq_stat_next, irq_set, irq_clr;
  logic irq_next, irq_reg;

  // Set wins over a write-one-to-clear landing in the same cycle
  always_comb begin
    irq_set = '0;
    if (sample_valid) begin
      for (int p = 0; p < 3; p++) begin
        if (pkirq_sel[p] && mag(phase_in[p].volt) > v_thr_reg) begin
          irq_set[`WPM_IRQ_V_BIT] = 1'b1;
        end
        if (pkirq_sel[p] && mag(phase_in[p].curr) > i_thr_reg) begin
          irq_set[`WPM_IRQ_I_BIT] = 1'b1;
        end
      end
    end
    irq_set[`WPM_IRQ_WIN_BIT] = win_end;
    irq_clr = (req.wr && hit(req.addr, `WPM_ADDR_IRQ_STAT)) ?
      req.wdata[`WPM_IRQ_W-1:0] : '0;
    irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_reg <= irq_next;
    end
  end
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // Waveform sampling and pulse routing
  // ----------------------------------------------------------------
  logic [11:0] div_cnt_reg, div_cnt_next, div_last;
  logic wave_stb_reg, wave_stb_next;
  logic signed [SW-1:0] wave_data_reg, wave_data_next;
  logic pulse_reg, pulse_next;
  wpm_phase_t sel_ph;

  // Period is 3 x (128 << code) cycles; reserved phase gives zero data
  always_comb begin
    div_last = 12'(`WPM_PRE_DIV * (`WPM_RATE_BASE << rate_sel)) - 12'h001;
    div_cnt_next = (div_cnt_reg >= div_last) ? 12'h000 :
      div_cnt_reg + 12'h001;
    wave_stb_next = (div_cnt_reg >= div_last);
    sel_ph = (ph_sel == 2'h3) ? '0 : phase_in[ph_sel];
    wave_data_next = wave_data_reg;
    if (wave_stb_next) begin
      case (wav_sel)
        WPM_WAV_CURR: wave_data_next = sel_ph.curr;
        WPM_WAV_VOLT: wave_data_next = sel_ph.volt;
        WPM_WAV_ACT: wave_data_next = sel_ph.act;
        WPM_WAV_REACT: wave_data_next = sel_ph.react;
        WPM_WAV_APP: wave_data_next = sel_ph.app;
        default: wave_data_next = '0; // Reserved type
      endcase
    end
    pulse_next = apparent_sel ? apparent_freq_in : reactive_freq_in;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_reg <= 12'h000;
      wave_stb_reg <= 1'b0;
      wave_data_reg <= '0;
      pulse_reg <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      wave_stb_reg <= wave_stb_next;
      wave_data_reg <= wave_data_next;
      pulse_reg <= pulse_next;
    end
  end
  assign wave_strobe = wave_stb_reg;
  assign wave_data = wave_data_reg;
  assign reactive_pulse_output = pulse_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_stb_phc_volt;
    wave_stb_next && ph_sel == 2'h2 && wav_sel == 3'h1;
  endsequence

  a_hold_reload: assert property (win_end |=>
    v_hold_reg == $past(v_run_reg) && i_hold_reg == $past(i_run_reg))
    else $error("peak hold not reloaded at window end");
  a_phase_a_peak: assert property (
    sample_valid && !win_end && peak_sel == 3'h1 &&
    mag(phase_in[0].volt) > v_run_reg |=>
    v_run_reg == $past(mag(phase_in[0].volt)))
    else $error("phase A voltage peak not captured");
  a_peak_off_hold: assert property (
    !win_end && peak_sel == 3'h0 |=> $stable(v_run_reg) && $stable(i_run_reg))
    else $error("peak tracked with no phase enabled");
  a_indep_track: assert property (
    sample_valid && !win_end && peak_sel == 3'h6 |=>
    v_run_reg >= $past(v_run_reg) && i_run_reg >= $past(i_run_reg))
    else $error("running peaks decreased inside window");
  a_irq_gate_off: assert property (
    pkirq_sel == 3'h0 |=> (irq_stat_reg[1:0] & ~$past(irq_stat_reg[1:0])) == 0)
    else $error("level flag set with monitoring off");
  a_multi_phase: assert property (
    sample_valid && pkirq_sel == 3'h6 && mag(phase_in[2].volt) > v_thr_reg
    |=> irq_stat_reg[`WPM_IRQ_V_BIT])
    else $error("phase C monitoring lost in multi-phase select");
  a_level_flag: assert property (
    |irq_set[1:0] |=> (irq_stat_reg[1:0] & $past(irq_set[1:0])) ==
    $past(irq_set[1:0]) ##1 (irq_reg || !(|(irq_stat_reg & irq_mask_reg))))
    else $error("level flag or interrupt output missing");
  a_wave_select: assert property (
    s_stb_phc_volt |=> wave_strobe && wave_data == $past(phase_in[2].volt))
    else $error("waveform source selection wrong");
  a_wave_type: assert property (
    wave_stb_next && wav_sel == 3'h0 && ph_sel == 2'h0 |=>
    wave_data == $past(phase_in[0].curr))
    else $error("waveform type selection wrong");
  a_rate_gap: assert property (
    wave_strobe && $stable(rate_sel) |=> (!wave_strobe) [*8])
    else $error("waveform strobes too close");
  a_pulse_route: assert property (
    apparent_sel |=> reactive_pulse_output == $past(apparent_freq_in))
    else $error("pulse output not routed to apparent source");
endmodule : wpm_config
`default_nettype wire

/* File: sim/wpm_config_tb.sv */
// Self-checking bench for the waveform and peak mode configuration block
`timescale 1ns/1ns
`default_nettype none
`include "wpm_map.svh"

module wpm_config_tb import wpm_pkg::*; ;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rstn;
  wpm_req_t req;
  logic [15:0] rdata;
  wpm_phase_t [2:0] phase_in;
  logic sample_valid, half_cycle, reactive_freq_in, apparent_freq_in;
  logic reactive_pulse_output, wave_strobe, irq;
  logic signed [23:0] wave_data;
  int n_mismatch = 0;
  int n_tests = 0;

  wpm_config #(.LCYC_W(16)) DUT (
    .core_clk(core_clk), .rstn(rstn), .req(req), .rdata(rdata),
    .phase_in(phase_in), .sample_valid(sample_valid),
    .half_cycle(half_cycle), .reactive_freq_in(reactive_freq_in),
    .apparent_freq_in(apparent_freq_in),
    .reactive_pulse_output(reactive_pulse_output),
    .wave_strobe(wave_strobe), .wave_data(wave_data), .irq(irq)
  );

  // Free-running 100 MHz clock
  always #5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge core_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd

  task automatic feed(input wpm_phase_t [2:0] p);
    @(posedge core_clk);
    phase_in <= p;
    sample_valid <= 1'b1;
    @(posedge core_clk);
    sample_valid <= 1'b0;
  endtask : feed

  task automatic pulse_half();
    @(posedge core_clk);
    half_cycle <= 1'b1;
    @(posedge core_clk);
    half_cycle <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : pulse_half

  // Bounded wait, so a dead strobe cannot hang the run
  task automatic next_strobe(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (wave_strobe !== 1'b1 && n < 4000);
  endtask : next_strobe

  function automatic int mag(input logic signed [23:0] x);
    return (x < 0) ? -int'(x) : int'(x);
  endfunction : mag

  // Negative values exercise the magnitude path
  function automatic logic signed [23:0] rnd24();
    int m;
    m = $urandom_range(24'h7FFFFF);
    return 24'(($urandom_range(1) != 0) ? -m : m);
  endfunction : rnd24

  function automatic logic [23:0] exp_wave(input wpm_phase_t [2:0] p,
                                           input int ph, input int t);
    if (ph == 3) return 24'h000000;
    case (t)
      0: return p[ph].curr;
      1: return p[ph].volt;
      2: return p[ph].act;
      3: return p[ph].react;
      4: return p[ph].app;
      default: return 24'h000000;
    endcase
  endfunction : exp_wave

  // Watchdog against a stalled design
  initial begin
    #900000;
    n_mismatch++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] v;
    logic rf, af;
    int n, vmax, imax;
    int vq[$], iq[$];
    wpm_phase_t [2:0] ph;
    rstn = 1'b0;
    req = '0;
    phase_in = '0;
    sample_valid = 1'b0;
    half_cycle = 1'b0;
    reactive_freq_in = 1'b0;
    apparent_freq_in = 1'b0;
    n = $urandom(32'h22F38053);
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    // Reset values and an unmapped read
    rd(`WPM_ADDR_MEAS_MODE, v);
    check("meas_mode", v, 16'h00FC);
    rd(`WPM_ADDR_WAVE_MODE, v);
    check("wave_mode", v, 16'h0000);
    rd(8'h3A, v);
    check("unmapped", v, 16'h0000);
    // Pulse output follows the selected source, one cycle late
    for (int s = 0; s < 2; s++) begin
      wr(`WPM_ADDR_WAVE_MODE, 16'(s << 7));
      for (int i = 0; i < 20; i++) begin
        rf = 1'($urandom);
        af = 1'($urandom);
        @(posedge core_clk);
        reactive_freq_in <= rf;
        apparent_freq_in <= af;
        @(posedge core_clk);
        #1;
        check("pulse_out", reactive_pulse_output, (s != 0) ? af : rf);
      end
    end
    // Every phase and type code at the fastest rate
    for (int k = 0; k < 3; k++) begin
      ph[k] = {rnd24(), rnd24(), rnd24(), rnd24(), rnd24()};
    end
    phase_in <= ph;
    for (int p = 0; p < 4; p++) begin
      for (int t = 0; t < 8; t++) begin
        wr(`WPM_ADDR_WAVE_MODE, 16'((t << 2) | p));
        rd(`WPM_ADDR_WAVE_MODE, v);
        check("wave_mode_rb", v, 16'((t << 2) | p));
        next_strobe(n);
        next_strobe(n);
        check("wave_data", wave_data[23:0], exp_wave(ph, p, t));
      end
    end
    // Strobe spacing for each rate code
    for (int r = 0; r < 4; r++) begin
      wr(`WPM_ADDR_WAVE_MODE, 16'(r << 5));
      next_strobe(n);
      next_strobe(n);
      next_strobe(n);
      check("strobe_gap", n, 3 * (128 << r));
    end
    // Peak capture for every nonzero phase selection, two half cycle window;
    // samples on both sides of the middle half cycle must all count
    wr(`WPM_ADDR_LINE_CYC, 16'h0002);
    for (int s = 1; s < 8; s++) begin
      wr(`WPM_ADDR_MEAS_MODE, 16'(s << 2));
      repeat (2) pulse_half();
      for (int j = 0; j < 3; j++) begin
        for (int k = 0; k < 3; k++) begin
          ph[k].volt = rnd24();
          ph[k].curr = rnd24();
          if (s[k]) begin
            vq.push_back(mag(ph[k].volt));
            iq.push_back(mag(ph[k].curr));
          end
        end
        feed(ph);
        if (j == 0) begin
          pulse_half();
        end
      end
      pulse_half();
      // Model: largest magnitude per quantity over the enabled phases
      vmax = 0;
      imax = 0;
      while (vq.size() > 0) begin
        n = vq.pop_front();
        vmax = (n > vmax) ? n : vmax;
        n = iq.pop_front();
        imax = (n > imax) ? n : imax;
      end
      rd(`WPM_ADDR_V_PEAK, v);
      check("volt_peak", v, 16'(vmax >> 8));
      rd(`WPM_ADDR_I_PEAK, v);
      check("curr_peak", v, 16'(imax >> 8));
      rd(`WPM_ADDR_IRQ_STAT, v);
      check("window_end", v[2], 1'b1);
      wr(`WPM_ADDR_IRQ_STAT, 16'h0007);
    end
    // Threshold monitoring, boundary value on the other phases
    wr(`WPM_ADDR_V_THRESH, 16'h0010);
    wr(`WPM_ADDR_IRQ_MASK, 16'h0001);
    for (int s = 1; s < 8; s++) begin
      wr(`WPM_ADDR_MEAS_MODE, 16'(s << 5));
      for (int p = 0; p < 3; p++) begin
        for (int k = 0; k < 3; k++) begin
          ph[k].volt = (k == p) ? -24'sh001001 : 24'sh001000;
          ph[k].curr = 24'sh000000;
        end
        feed(ph);
        repeat (3) @(posedge core_clk);
        #1;
        check("irq", irq, s[p]);
        rd(`WPM_ADDR_IRQ_STAT, v);
        check("irq_stat", v, 16'(s[p]));
        wr(`WPM_ADDR_IRQ_STAT, 16'h0007);
        repeat (3) @(posedge core_clk);
      end
    end
    // A masked flag stays set but keeps the output low
    feed(ph);
    wr(`WPM_ADDR_IRQ_MASK, 16'h0000);
    repeat (3) @(posedge core_clk);
    #1;
    check("irq_masked", irq, 1'b0);
    rd(`WPM_ADDR_IRQ_STAT, v);
    check("stat_masked", v, 16'h0001);
    conclude();
  end
endmodule : wpm_config_tb

`default_nettype wire
